//--- hw/spg_pkg.sv
// Shared constants and types for the stepper pattern generator
package spg_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] ADDR_TRIG_SEL = 8'h4a;
    localparam logic [7:0] ADDR_CTRL = 8'h4b;
    localparam logic [7:0] ADDR_CH0 = 8'h4c;
    localparam logic [7:0] ADDR_CH1 = 8'h4d;
    localparam logic [7:0] ADDR_FUNC_LO = 8'h4e;
    localparam logic [7:0] ADDR_FUNC_HI = 8'h4f;

    // Control register: one nibble per channel, channel one on top
    localparam int CTL_CH_W = 4;
    localparam int CTL_MODE = 0;
    localparam int CTL_HALF = 1;
    localparam int CTL_DIR = 2;
    localparam int CTL_PAT = 3;

    // Trigger select register: two bits per channel
    localparam int TSEL_CH_W = 2;

    // Channel data register layout
    localparam int DATA_LATCH_LSB = 4;
    localparam int DATA_ALT_LSB = 0;

    // Port function registers: two bits per pin, upper one picks pattern
    localparam int FUNC_PIN_W = 2;
    localparam int FUNC_PAT_BIT = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TSEL_RST = 8'h00;
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [3:0] LATCH_RST = 4'h0;
    localparam logic [3:0] ALT_RST = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Trigger source of a channel
    typedef enum logic [1:0] {
        SRC_TMR_EVEN = 2'b00,
        SRC_TMR_ODD = 2'b01,
        SRC_WIDE = 2'b11,
        SRC_NONE = 2'b10
    } spg_src_t;

    // Operating mode of an eight-bit timer pair
    typedef enum logic [1:0] {
        TM8_8BIT = 2'b00,
        TM8_16BIT = 2'b01,
        TM8_PPG = 2'b10,
        TM8_PWM = 2'b11
    } spg_tm8_mode_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spg_bus_t;

    // Eight-bit timer status, pair 0 = timers 0/1, pair 1 = timers 2/3
    typedef struct packed {
        logic [3:0] match;
        logic [1:0] flop_inv_en;
        spg_tm8_mode_t mode1;
        spg_tm8_mode_t mode0;
    } spg_tm8_t;

    // Sixteen-bit timer status
    typedef struct packed {
        logic match_b;
        logic cmp_b_trig_en;
        logic cmp_b_alt_trig_en;
    } spg_wide_t;

endpackage

//--- hw/spg_stepper_pattern_generator.sv
// Two-channel stepping motor / pattern generator with port pin mux
// Functional notes
// - Two independent 4-bit channels, each with own trigger, direction, mode.
// - Channel 0 triggers from timer 0/1 or 4; channel 1 from 2/3 or 4.
// - Stepping modes shift the latch once per trigger rising edge onto pins.
// - Direction 0 moves bit 0 toward 3; direction 1 moves bit 3 toward 0.
// - One- and two-phase modes ignore the alternate register.
// - Half-step rotates latch and alternate as ring b7 b3 b6 b2 b5 b1 b4 b0.
// - Pattern mode blocks latch writes; shifting as in half-step.
// - Data register: latch bits 7..4 write-only, alternate bits 3..0 r/w.
// - Pair in PPG mode triggers on cycle match only, not duty match.
// - Timer in PWM mode gives no shift trigger.
// - Eight-bit timer triggers pass only while flop inversion is enabled.
// - Wide timer trigger on compare B match, needing an enable bit set.
// - Each shared pin chooses port or pattern output individually.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module spg_stepper_pattern_generator
    import spg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire spg_bus_t bus, // Register port request
    output logic [7:0] rdata, // Read data, cycle after read strobe
    input wire spg_tm8_t tm8, // Eight-bit timer status
    input wire spg_wide_t wide, // Sixteen-bit timer status
    input wire logic [7:0] port_data, // Ordinary port output values
    output logic [7:0] shared_port_six, // Pin output values
    output logic [7:0] pin_pattern_sel, // Pin carries pattern output
    output logic [3:0] pattern_chan_zero, // Channel zero latch
    output logic [3:0] pattern_chan_one // Channel one latch
);

    // Address match shared by read and write decode
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
        addr_hit = (a == t);
    endfunction

    // Interleave latch and alternate into the half-step ring
    function automatic logic [7:0] ring_pack(input logic [3:0] l, input logic [3:0] s);
        ring_pack = {l[3], s[3], l[2], s[2], l[1], s[1], l[0], s[0]};
    endfunction

    // Trigger from an eight-bit timer pair by its mode
    function automatic logic pair_trig(
        input logic m_even,
        input logic m_odd,
        input logic inv_en,
        input spg_tm8_mode_t md,
        input spg_src_t src
    );
        logic ev;
        ev = 1'b0;
        // Cascaded and PPG pairs step on the odd timer's cycle match only
        unique case (md)
            TM8_8BIT: ev = (src == SRC_TMR_EVEN) ? m_even : m_odd;
            TM8_16BIT: ev = m_odd;
            TM8_PPG: ev = m_odd;
            TM8_PWM: ev = 1'b0;
        endcase
        // Gate by the pair's flop inversion enable
        pair_trig = ev & inv_en;
    endfunction

    // Shared control state
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] tsel_ff;
    logic [7:0] nxt_tsel;
    logic [15:0] func_ff;
    logic [15:0] nxt_func;

    // Registered outputs
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] pins_ff;
    logic [7:0] nxt_pins;
    logic [7:0] psel_ff;
    logic [7:0] nxt_psel;

    // Channel latches and alternates gathered for the read and pin muxes
    wire [7:0] latch_all;
    wire [7:0] alt_all;

    // Write strobes of the shared registers
    logic wr_ctrl;
    logic wr_tsel;
    logic wr_flo;
    logic wr_fhi;

    // Write decode for shared registers
    always_comb begin
        wr_ctrl = bus.wr & addr_hit(bus.addr, ADDR_CTRL);
        wr_tsel = bus.wr & addr_hit(bus.addr, ADDR_TRIG_SEL);
        wr_flo = bus.wr & addr_hit(bus.addr, ADDR_FUNC_LO);
        wr_fhi = bus.wr & addr_hit(bus.addr, ADDR_FUNC_HI);
    end

    // Next values of shared configuration
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_tsel = tsel_ff;
        nxt_func = func_ff;
        // Unmapped addresses match no strobe and change nothing
        if (wr_ctrl) begin
            nxt_ctrl = bus.wdata;
        end
        if (wr_tsel) begin
            nxt_tsel = bus.wdata;
        end
        if (wr_flo) begin
            nxt_func[7:0] = bus.wdata;
        end
        if (wr_fhi) begin
            nxt_func[15:8] = bus.wdata;
        end
    end

    // Shared configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            // Reset leaves every pin in port use and both channels idle
            ctrl_ff <= CTRL_RST;
            tsel_ff <= TSEL_RST;
            func_ff <= {FUNC_RST, FUNC_RST};
        end else begin
            ctrl_ff <= nxt_ctrl;
            tsel_ff <= nxt_tsel;
            func_ff <= nxt_func;
        end
    end

    // Per-channel trigger, shifter and data register
    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            // Trigger path
            logic [3:0] ctl;
            spg_src_t src;
            logic raw_trig;
            logic trig_prev_ff;
            logic nxt_trig_prev;
            logic step;
            logic wr_data;
            logic pat_mode;

            // Latch, alternate and half-step ring
            logic [3:0] latch_ff;
            logic [3:0] alt_ff;
            logic [3:0] nxt_latch;
            logic [3:0] nxt_alt;
            logic [7:0] ring;
            logic [7:0] ring_sh;

            // Channel slices of the shared registers and its data strobe
            assign ctl = ctrl_ff[c*CTL_CH_W +: CTL_CH_W];
            assign src = spg_src_t'(tsel_ff[c*TSEL_CH_W +: TSEL_CH_W]);
            assign pat_mode = ctl[CTL_MODE] & ctl[CTL_PAT];
            assign wr_data = bus.wr & addr_hit(bus.addr, c ? ADDR_CH1 : ADDR_CH0);

            // Select the channel's trigger source
            always_comb begin
                raw_trig = 1'b0;
                unique case (src)
                    SRC_TMR_EVEN, SRC_TMR_ODD: begin
                        raw_trig = pair_trig(tm8.match[2*c], tm8.match[2*c+1],
                            tm8.flop_inv_en[c], c ? tm8.mode1 : tm8.mode0, src);
                    end
                    SRC_WIDE: begin
                        raw_trig = wide.match_b
                            & (wide.cmp_b_trig_en | wide.cmp_b_alt_trig_en);
                    end
                    SRC_NONE: raw_trig = 1'b0;
                endcase
            end

            // One step per rising edge of the selected trigger
            // A held trigger level steps once; it must fall before the next
            assign step = raw_trig & ~trig_prev_ff;

            // Trigger history for the edge detector
            always_comb begin
                nxt_trig_prev = raw_trig;
            end

            // Trigger history register; clears low to match an idle trigger
            always_ff @(posedge clk) begin
                if (srst) begin
                    trig_prev_ff <= 1'b0;
                end else begin
                    trig_prev_ff <= nxt_trig_prev;
                end
            end

            // Rotate the half-step ring in the chosen direction
            always_comb begin
                ring = ring_pack(latch_ff, alt_ff);
                // Normal turn moves r0 toward carrying latch bit 0 up to bit 3
                if (ctl[CTL_DIR]) begin
                    ring_sh = {ring[0], ring[7:1]};
                end else begin
                    ring_sh = {ring[6:0], ring[7]};
                end
            end

            // Next latch and alternate values
            always_comb begin
                nxt_latch = latch_ff;
                nxt_alt = alt_ff;
                if (ctl[CTL_MODE] && step) begin
                    if (ctl[CTL_HALF] || ctl[CTL_PAT]) begin
                        nxt_latch = {ring_sh[7], ring_sh[5], ring_sh[3], ring_sh[1]};
                        nxt_alt = {ring_sh[6], ring_sh[4], ring_sh[2], ring_sh[0]};
                    end else if (ctl[CTL_DIR]) begin
                        nxt_latch = {latch_ff[0], latch_ff[3:1]};
                    end else begin
                        nxt_latch = {latch_ff[2:0], latch_ff[3]};
                    end
                end
                // Software write overrides the shift for written fields
                // In pattern mode the latch keeps shifting while the alternate refills
                if (wr_data) begin
                    nxt_alt = bus.wdata[DATA_ALT_LSB +: 4];
                    if (!pat_mode) begin
                        nxt_latch = bus.wdata[DATA_LATCH_LSB +: 4];
                    end
                end
            end

            // Channel state registers
            always_ff @(posedge clk) begin
                if (srst) begin
                    latch_ff <= LATCH_RST;
                    // Alternate has no defined power-up value; cleared for repeatability
                    alt_ff <= ALT_RST;
                end else begin
                    latch_ff <= nxt_latch;
                    alt_ff <= nxt_alt;
                end
            end

            // Gather channel state for the read and pin muxes
            assign latch_all[c*4 +: 4] = latch_ff;
            assign alt_all[c*4 +: 4] = alt_ff;
        end
    endgenerate

    // Read mux; latch half reads as zero
    // The latch half is write-only, so a read-modify-write would clear it
    always_comb begin
        nxt_rdata = RDATA_IDLE;
        if (bus.rd) begin
            if (addr_hit(bus.addr, ADDR_CH0)) begin
                nxt_rdata = {4'h0, alt_all[3:0]};
            end else if (addr_hit(bus.addr, ADDR_CH1)) begin
                nxt_rdata = {4'h0, alt_all[7:4]};
            end else if (addr_hit(bus.addr, ADDR_CTRL)) begin
                nxt_rdata = ctrl_ff;
            end else if (addr_hit(bus.addr, ADDR_TRIG_SEL)) begin
                nxt_rdata = tsel_ff;
            end else if (addr_hit(bus.addr, ADDR_FUNC_LO)) begin
                nxt_rdata = func_ff[7:0];
            end else if (addr_hit(bus.addr, ADDR_FUNC_HI)) begin
                nxt_rdata = func_ff[15:8];
            end
        end
    end

    // Pin mux, one function bit per pin
    // Pin select is registered beside the pins so both change on one edge
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            nxt_psel[i] = func_ff[i*FUNC_PIN_W + FUNC_PAT_BIT];
            nxt_pins[i] = nxt_psel[i] ? latch_all[i] : port_data[i];
        end
    end

    // Output registers
    // Read data falls back to zero when no read is pending
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= RDATA_IDLE;
            pins_ff <= 8'h00;
            psel_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
            pins_ff <= nxt_pins;
            psel_ff <= nxt_psel;
        end
    end

    // Ports straight from flip-flops
    assign rdata = rdata_ff;
    assign shared_port_six = pins_ff;
    assign pin_pattern_sel = psel_ff;
    assign pattern_chan_zero = latch_all[3:0];
    assign pattern_chan_one = latch_all[7:4];

endmodule

//--- tb/spg_checker.sv
// Port-level checks for the stepper pattern generator
`timescale 1ns/1ps
module spg_checker
    import spg_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire spg_bus_t bus, // Register port
    input wire logic [7:0] rdata, // Read data
    input wire spg_tm8_t tm8, // Timer pairs
    input wire spg_wide_t wide, // Wide timer
    input wire logic [7:0] port_data, // Port values
    input wire logic [7:0] shared_port_six, // Pins
    input wire logic [7:0] pin_pattern_sel, // Pin select
    input wire logic [3:0] pattern_chan_zero, // Latch zero
    input wire logic [3:0] pattern_chan_one // Latch one
);
    logic [7:0] ctrl_ff;
    logic [1:0] src_ff;
    logic w0, pm0, quiet;
    // Shadow of channel zero configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= CTRL_RST;
            src_ff <= TSEL_RST[1:0];
        end else if (bus.wr && bus.addr == ADDR_CTRL) begin
            ctrl_ff <= bus.wdata;
        end else if (bus.wr && bus.addr == ADDR_TRIG_SEL) begin
            src_ff <= bus.wdata[1:0];
        end
    end
    // Qualifiers
    assign w0 = bus.wr && bus.addr == ADDR_CH0;
    assign pm0 = ctrl_ff[CTL_MODE] && ctrl_ff[CTL_PAT];
    assign quiet = tm8.match == 4'h0 && !wide.match_b;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!bus.rd |=> rdata == RDATA_IDLE)
        else $error("rdata not idle");
    a_latch_write: assert property (w0 && !pm0 |=> pattern_chan_zero == $past(bus.wdata[7:4]))
        else $error("latch write lost");
    a_pat_block: assert property (w0 && pm0 && quiet |=> $stable(pattern_chan_zero))
        else $error("latch written in pattern mode");
    a_idle_hold: assert property (!ctrl_ff[CTL_MODE] && !w0 |=> $stable(pattern_chan_zero))
        else $error("latch moved while idle");
    a_pwm_none: assert property (tm8.mode0 == TM8_PWM && src_ff != SRC_WIDE && !w0 |=>
        $stable(pattern_chan_zero)) else $error("step in pwm mode");
    a_flop_gate: assert property (!tm8.flop_inv_en[0] && src_ff != SRC_WIDE && !w0 |=>
        $stable(pattern_chan_zero)) else $error("step with flop disabled");
    a_wide_gate: assert property (src_ff == SRC_WIDE && !wide.cmp_b_trig_en &&
        !wide.cmp_b_alt_trig_en && !w0 |=> $stable(pattern_chan_zero)) else $error("wide step");
    a_pins_follow: assert property (!$past(srst) && $stable(pin_pattern_sel) |->
        shared_port_six == ((pin_pattern_sel & $past({pattern_chan_one, pattern_chan_zero}))
        | (~pin_pattern_sel & $past(port_data)))) else $error("pin mux wrong");
    // Main scenarios
    c_pat_write: cover property (w0 && pm0);
    c_half_step: cover property (ctrl_ff[CTL_HALF] && !$stable(pattern_chan_zero));
    c_wide_trig: cover property (src_ff == SRC_WIDE && wide.match_b);
endmodule
bind spg_stepper_pattern_generator spg_checker chk_u (.clk(clk), .srst(srst), .bus(bus),
    .rdata(rdata), .tm8(tm8), .wide(wide), .port_data(port_data),
    .shared_port_six(shared_port_six), .pin_pattern_sel(pin_pattern_sel),
    .pattern_chan_zero(pattern_chan_zero), .pattern_chan_one(pattern_chan_one));

//--- tb/spg_motor_model.sv
// Motor driver stage model latching coil levels from the pins
`timescale 1ns/1ps
module spg_motor_model
    import spg_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic [7:0] pins, // Pin levels
    input wire logic [7:0] sel, // Pins in pattern use
    output logic [7:0] coil // Coil drive seen
);
    // Pins in port use drive no coil
    always_ff @(posedge clk) begin
        coil <= pins & sel;
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the stepper pattern generator
`timescale 1ns/1ps
module testbench;
    import spg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    spg_bus_t bus_r = '0;
    spg_tm8_t tm8_r = '0;
    spg_wide_t wide_r = '0;
    logic [7:0] pdata = 8'h00;
    logic [7:0] rdata, pins, sel, coil, v, e;
    logic [3:0] l0, l1;
    logic [31:0] seed = 32'h51ee;
    logic [7:0] addrs [8] = '{8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h00, 8'h50};
    spg_tm8_mode_t gmode [4] = '{TM8_PWM, TM8_8BIT, TM8_PPG, TM8_PPG};
    logic [4:0] wm [4] = '{5'h10, 5'h10, 5'h04, 5'h01};
    int error_cnt = 0;
    int compares = 0;
    always #5 clk = ~clk;
    spg_stepper_pattern_generator dut_u (.clk(clk), .srst(srst), .bus(bus_r), .rdata(rdata),
        .tm8(tm8_r), .wide(wide_r), .port_data(pdata), .shared_port_six(pins),
        .pin_pattern_sel(sel), .pattern_chan_zero(l0), .pattern_chan_one(l1));
    spg_motor_model mdl_u (.clk(clk), .pins(pins), .sel(sel), .coil(coil));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [3:0] rot4(input logic [3:0] x, input logic d);
        return d ? {x[0], x[3:1]} : {x[2:0], x[3]};
    endfunction
    // Interleaved ring step of latch and alternate
    function automatic logic [7:0] ring(input logic [7:0] x, input logic d);
        logic [7:0] r;
        r = {x[7], x[3], x[6], x[2], x[5], x[1], x[4], x[0]};
        r = d ? {r[0], r[7:1]} : {r[6:0], r[7]};
        return {r[7], r[5], r[3], r[1], r[6], r[4], r[2], r[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_r.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_r <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_r.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // One-cycle timer match, then let the step land
    task automatic trig(input logic [4:0] m);
        @(posedge clk);
        {wide_r.match_b, tm8_r.match} <= m;
        @(posedge clk);
        {wide_r.match_b, tm8_r.match} <= 5'h00;
        repeat (2) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        tm8_r.flop_inv_en <= 2'b11;
        foreach (addrs[i]) begin
            rd(addrs[i], v);
            chk("reset_read", 8'h00, v);
        end
        wr(ADDR_FUNC_LO, 8'haa);
        // One- and two-phase both ways, random alternate ignored
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            e = {i[1] ? 4'h6 : 4'h1 << seed[1:0], seed[7:4]};
            wr(ADDR_CTRL, i[0] ? 8'h05 : 8'h01);
            wr(ADDR_CH0, e);
            repeat (3) begin
                trig(5'h01);
                e[7:4] = rot4(e[7:4], i[0]);
                chk("latch0", {4'h0, e[7:4]}, {4'h0, l0});
            end
            repeat (2) @(negedge clk);
            chk("coil", {4'h0, e[7:4]}, coil);
        end
        // Half-step ring, positive then negative logic
        for (int i = 0; i < 2; i++) begin
            e = i[0] ? 8'h37 : 8'hc8;
            wr(ADDR_CTRL, i[0] ? 8'h07 : 8'h03);
            wr(ADDR_CH0, e);
            repeat (5) begin
                trig(5'h01);
                e = ring(e, i[0]);
                chk("latch0", {4'h0, e[7:4]}, {4'h0, l0});
            end
            rd(ADDR_CH0, v);
            chk("alt0", {4'h0, e[3:0]}, v);
        end
        // Pattern mode drops the latch half of writes
        wr(ADDR_CTRL, 8'h09);
        repeat (3) begin
            seed = xs(seed);
            wr(ADDR_CH0, seed[7:0]);
            e[3:0] = seed[3:0];
            @(negedge clk);
            chk("latch0", {4'h0, e[7:4]}, {4'h0, l0});
            trig(5'h01);
            e = ring(e, 1'b0);
            chk("latch0", {4'h0, e[7:4]}, {4'h0, l0});
        end
        // Timer mode and flop enable gating
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CH0, 8'h10);
        e = 8'h01;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tm8_r.mode0 <= gmode[i];
            tm8_r.flop_inv_en[0] <= i != 1;
            trig(i == 3 ? 5'h02 : 5'h01);
            if (i == 3) e[3:0] = rot4(e[3:0], 1'b0);
            chk("latch0", e, {4'h0, l0});
        end
        // Channel zero on the wide timer, channel one on timer two
        wr(ADDR_TRIG_SEL, 8'h03);
        tm8_r.mode0 <= TM8_8BIT;
        wr(ADDR_CTRL, 8'h11);
        wr(ADDR_CH1, 8'h80);
        e = {4'h8, e[3:0]};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            wide_r.cmp_b_trig_en <= i > 0;
            trig(wm[i]);
            if (i == 1) e[3:0] = rot4(e[3:0], 1'b0);
            if (i == 2) e[7:4] = rot4(e[7:4], 1'b0);
            chk("latches", e, {l1, l0});
        end
        // No source: every match ignored
        wr(ADDR_TRIG_SEL, 8'h0a);
        trig(5'h1f);
        chk("latches", e, {l1, l0});
        // Channel one on the odd timer of a cascaded pair, reverse, upper pins in use
        wr(ADDR_TRIG_SEL, 8'h07);
        wr(ADDR_CTRL, 8'h51);
        wr(ADDR_FUNC_HI, 8'haa);
        tm8_r.mode1 <= TM8_16BIT;
        for (int i = 0; i < 2; i++) begin
            trig(i == 0 ? 5'h04 : 5'h08);
            if (i == 1) e[7:4] = rot4(e[7:4], 1'b1);
            chk("latches", e, {l1, l0});
        end
        repeat (2) @(negedge clk);
        chk("coil", e, coil);
        rd(ADDR_CTRL, v);
        chk("ctrl_read", 8'h51, v);
        // Pins back in port use show port data
        wr(ADDR_FUNC_LO, 8'h00);
        wr(ADDR_FUNC_HI, 8'h00);
        repeat (4) begin
            seed = xs(seed);
            @(posedge clk);
            pdata <= seed[7:0];
            repeat (2) @(negedge clk);
            chk("pins", seed[7:0], pins);
        end
        results();
    end
endmodule
